// [hdl/aao_core.sv]
/*
  Eight-channel AES-to-analog output processor: fade switching,
  word-length handling, dither, presence detection, channel-status
  handling, monitor tap and matched-delay rate-converter grouping,
  with an AXI4-Lite register slave.
  Assumes AES inputs arrive on mclk from the crosspoint logic and
  that rate converters and DACs sit outside behind the pcm ports.
*/
`include "aao_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module aao_core #(
  parameter int N_CH = 8
) (
  // Clock, reset, enable
  input  wire logic                mclk,
  input  wire logic                rst_n,
  input  wire logic                clk_en,
  // AES inputs from crosspoint
  input  wire aao_pkg::aao_aes_t   aes_in [N_CH],
  // Rate converter / DAC feed, two channels per AES input
  output aao_pkg::aao_pcm_t        pcm_out [N_CH],
  output logic [N_CH-1:0]          conv_grouped,
  output logic [N_CH-1:0]          conv_phase_src,
  output logic                     dac_tick,
  // Monitor matrix tap
  output aao_pkg::aao_pcm_t        mon_out [N_CH],
  // Interrupt
  output logic                     irq,
  // AXI4-Lite slave
  input  wire logic [11:0]         s_awaddr,
  input  wire logic                s_awvalid,
  output logic                     s_awready,
  input  wire logic [31:0]         s_wdata,
  input  wire logic [3:0]          s_wstrb,
  input  wire logic                s_wvalid,
  output logic                     s_wready,
  output logic [1:0]               s_bresp,
  output logic                     s_bvalid,
  input  wire logic                s_bready,
  input  wire logic [11:0]         s_araddr,
  input  wire logic                s_arvalid,
  output logic                     s_arready,
  output logic [31:0]              s_rdata,
  output logic [1:0]               s_rresp,
  output logic                     s_rvalid,
  input  wire logic                s_rready
);

  localparam int NP = N_CH / 2;

  logic [31:0]       ctrl_q;
  logic [3*N_CH-1:0] srcsel_q;
  logic [NP-1:0]     group_q;
  logic [2:0]        master_q;
  logic [N_CH-1:0]   irq_stat_q;
  logic [N_CH-1:0]   irq_mask_q;
  logic [2*N_CH-1:0] pres_q;
  logic [N_CH-1:0]   fading;
  logic [N_CH-1:0]   fade_done;
  logic [N_CH-1:0]   sel_wr;
  logic [2*N_CH-1:0] pres_d;

  // AXI write channel: accept address and data in either order
  logic [11:0] aw_q;
  logic        aw_have_q;
  logic [31:0] w_q;
  logic [3:0]  ws_q;
  logic        w_have_q;
  logic        wr_go;
  assign wr_go = aw_have_q & w_have_q & ~s_bvalid;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_q      <= 12'h000;
      w_q       <= 32'h0000_0000;
      ws_q      <= 4'h0;
      s_bvalid  <= 1'b0;
      s_bresp   <= 2'b00;
    end else if (clk_en) begin
      if (s_awvalid && s_awready) begin
        aw_q      <= s_awaddr;
        aw_have_q <= 1'b1;
      end
      if (s_wvalid && s_wready) begin
        w_q      <= s_wdata;
        ws_q     <= s_wstrb;
        w_have_q <= 1'b1;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        s_bvalid  <= 1'b1;
        s_bresp   <= (aw_q > `AAO_OFS_PRESENCE) ? 2'b10 : 2'b00;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_awready <= 1'b0;
      s_wready  <= 1'b0;
    end else if (clk_en) begin
      s_awready <= ~aw_have_q & ~(s_awvalid & s_awready);
      s_wready  <= ~w_have_q & ~(s_wvalid & s_wready);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q     <= `AAO_CTRL_RST;
      srcsel_q   <= '0;
      group_q    <= `AAO_GROUP_RST;
      master_q   <= `AAO_MASTER_RST;
      irq_mask_q <= '0;
    end else if (clk_en && wr_go && ws_q[0]) begin
      case (aw_q)
        `AAO_OFS_CTRL:     ctrl_q <= w_q;
        `AAO_OFS_SRCSEL:   srcsel_q <= w_q[3*N_CH-1:0];
        `AAO_OFS_GROUP:    group_q <= w_q[NP-1:0];
        `AAO_OFS_MASTER:   master_q <= w_q[2:0];
        `AAO_OFS_IRQ_MASK: irq_mask_q <= w_q[N_CH-1:0];
        default: ;
      endcase
    end
  end

  // Source select written: per-channel change request
  always_comb begin
    for (int i = 0; i < N_CH; i++) begin
      sel_wr[i] = wr_go && ws_q[0] && (aw_q == `AAO_OFS_SRCSEL)
                  && (w_q[3*i +: 3] != srcsel_q[3*i +: 3]);
    end
  end

  // Fade completion is sticky; set wins over write-one clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= '0;
      irq        <= 1'b0;
    end else if (clk_en) begin
      irq_stat_q <= (irq_stat_q & ~((wr_go && aw_q == `AAO_OFS_IRQ_STAT)
                    ? w_q[N_CH-1:0] : '0)) | fade_done;
      irq        <= |(irq_stat_q & irq_mask_q);
    end
  end

  // AXI read channel
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0000_0000;
      s_rresp   <= 2'b00;
    end else if (clk_en) begin
      s_arready <= ~s_rvalid & ~(s_arvalid & s_arready);
      if (s_arvalid && s_arready) begin
        s_rvalid <= 1'b1;
        s_rresp  <= 2'b00;
        case (s_araddr)
          `AAO_OFS_CTRL:     s_rdata <= ctrl_q;
          `AAO_OFS_SRCSEL:   s_rdata <= 32'(srcsel_q);
          `AAO_OFS_GROUP:    s_rdata <= 32'(group_q);
          `AAO_OFS_MASTER:   s_rdata <= 32'(master_q);
          `AAO_OFS_STATUS:   s_rdata <= 32'(fading);
          `AAO_OFS_IRQ_STAT: s_rdata <= 32'(irq_stat_q);
          `AAO_OFS_IRQ_MASK: s_rdata <= 32'(irq_mask_q);
          `AAO_OFS_PRESENCE: s_rdata <= 32'(pres_q);
          default: begin
            s_rdata <= 32'h0000_0000;
            s_rresp <= 2'b10;
          end
        endcase
      end else if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  // 48 kHz output tick from local clock
  logic [11:0] div_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_q    <= 12'h000;
      dac_tick <= 1'b0;
    end else if (clk_en) begin
      dac_tick <= (div_q == 12'(`AAO_OUT_DIV - 1));
      div_q    <= (div_q == 12'(`AAO_OUT_DIV - 1)) ? 12'h000
                  : div_q + 12'h001;
    end
  end

  // Dither source: shared LFSR
  logic [15:0] lfsr_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr_q <= 16'hACE1;
    end else if (clk_en) begin
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12]
                 ^ lfsr_q[10]};
    end
  end

  // master effective only if its pair is grouped
  logic master_ok;
  assign master_ok = group_q[master_q[2:1]];

  // one independent chain per AES input
  genvar g;
  generate
    for (g = 0; g < N_CH; g++) begin : g_ch
      aao_pkg::aao_fade_t st_q;
      logic [15:0] gain_q;
      logic [15:0] wait_q;
      logic        async_q;
      logic [23:0] mask;
      logic [23:0] l_m;
      logic [23:0] r_m;
      logic [23:0] l_abs;
      logic [23:0] r_abs;
      logic [39:0] l_p;
      logic [39:0] r_p;

      always_comb begin
        case (aes_in[g].wlen)
          2'd0:    mask = 24'hFF_FF00;
          2'd1:    mask = 24'hFF_FFF0;
          default: mask = 24'hFF_FFFF;
        endcase
        l_m = aes_in[g].left & mask;
        r_m = aes_in[g].right & mask;
        l_p = $signed(l_m) * $signed({1'b0, gain_q});
        r_p = $signed(r_m) * $signed({1'b0, gain_q});
        l_abs = l_m[23] ? -l_m : l_m;
        r_abs = r_m[23] ? -r_m : r_m;
      end

      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          st_q    <= aao_pkg::AAO_IDLE;
          gain_q  <= `AAO_GAIN_FULL;
          wait_q  <= 16'h0000;
          async_q <= 1'b0;
        end else if (clk_en) begin
          case (st_q)
            aao_pkg::AAO_IDLE:
              if (sel_wr[g]) begin
                st_q    <= aao_pkg::AAO_DOWN;
                async_q <= ~aes_in[g].sync_ok;
              end
            aao_pkg::AAO_DOWN:
              if (aes_in[g].valid) begin
                if (gain_q <= `AAO_FADE_STEP) begin
                  gain_q <= 16'h0000;
                  st_q   <= aao_pkg::AAO_SWITCH;
                end else begin
                  gain_q <= gain_q - `AAO_FADE_STEP;
                end
              end
            aao_pkg::AAO_SWITCH: begin
              // relock time if either source is asynchronous
              wait_q <= (async_q | ~aes_in[g].sync_ok)
                        ? `AAO_RELOCK_SAMPLES : 16'h0000;
              st_q   <= aao_pkg::AAO_RELOCK;
            end
            aao_pkg::AAO_RELOCK:
              if (wait_q == 16'h0000) begin
                st_q <= aao_pkg::AAO_UP;
              end else if (aes_in[g].valid) begin
                wait_q <= wait_q - 16'h0001;
              end
            aao_pkg::AAO_UP:
              if (aes_in[g].valid) begin
                if (gain_q >= `AAO_GAIN_FULL - `AAO_FADE_STEP) begin
                  gain_q <= `AAO_GAIN_FULL;
                  st_q   <= aao_pkg::AAO_IDLE;
                end else begin
                  gain_q <= gain_q + `AAO_FADE_STEP;
                end
              end
            default: st_q <= aao_pkg::AAO_IDLE;
          endcase
        end
      end

      assign fading[g]    = (st_q != aao_pkg::AAO_IDLE);
      assign fade_done[g] = (st_q == aao_pkg::AAO_UP) && aes_in[g].valid
                    && (gain_q >= `AAO_GAIN_FULL - `AAO_FADE_STEP);
      assign pres_d[2*g]   = l_abs > `AAO_PRES_THRESH;
      assign pres_d[2*g+1] = r_abs > `AAO_PRES_THRESH;

      // two channels out; monitor tap equals converter feed
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          pcm_out[g] <= '0;
          mon_out[g] <= '0;
          pres_q[2*g +: 2] <= 2'b00;
        end else if (clk_en) begin
          pcm_out[g].valid <= aes_in[g].valid & ctrl_q[`AAO_CTRL_EN];
          mon_out[g].valid <= aes_in[g].valid & ctrl_q[`AAO_CTRL_EN];
          if (aes_in[g].valid) begin
            pres_q[2*g +: 2] <= pres_d[2*g +: 2];
            pcm_out[g].left  <= l_p[39:16] + (ctrl_q[`AAO_CTRL_DITHER]
                                ? {{23{1'b0}}, lfsr_q[g]} : 24'h00_0000);
            pcm_out[g].right <= r_p[39:16] + (ctrl_q[`AAO_CTRL_DITHER]
                                ? {{23{1'b0}}, lfsr_q[g+1]} : 24'h00_0000);
            mon_out[g].left  <= l_p[39:16] + (ctrl_q[`AAO_CTRL_DITHER]
                                ? {{23{1'b0}}, lfsr_q[g]} : 24'h00_0000);
            mon_out[g].right <= r_p[39:16] + (ctrl_q[`AAO_CTRL_DITHER]
                                ? {{23{1'b0}}, lfsr_q[g+1]} : 24'h00_0000);
            // status follows input, word length marked 24 bits
            pcm_out[g].cbits <= {aes_in[g].cbits[7:2], 2'b11};
            mon_out[g].cbits <= {aes_in[g].cbits[7:2], 2'b11};
          end
        end
      end

      // per-channel converter grouping and phase source
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          conv_grouped[g]   <= 1'b0;
          conv_phase_src[g] <= 1'b0;
        end else if (clk_en) begin
          conv_grouped[g]   <= group_q[g/2] & master_ok;
          conv_phase_src[g] <= master_ok && (master_q == 3'(g));
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// [shared/aao_defines.svh]
/*
  Register offsets, field positions, reset values and timing counts
  for the AES-to-analog output processor.
  Assumes inclusion by bare name from the design and bench files.
*/
`ifndef AAO_DEFINES_SVH
`define AAO_DEFINES_SVH

// Register byte offsets
`define AAO_OFS_CTRL      12'h000
`define AAO_OFS_SRCSEL    12'h004
`define AAO_OFS_GROUP     12'h008
`define AAO_OFS_MASTER    12'h00C
`define AAO_OFS_STATUS    12'h010
`define AAO_OFS_IRQ_STAT  12'h014
`define AAO_OFS_IRQ_MASK  12'h018
`define AAO_OFS_PRESENCE  12'h01C

// Control register fields
`define AAO_CTRL_DITHER   0
`define AAO_CTRL_EN       1

// Reset values
`define AAO_CTRL_RST      32'h0000_0002
`define AAO_GROUP_RST     4'h0
`define AAO_MASTER_RST    3'h0

// Fade step per sample and its full-scale gain
`define AAO_FADE_STEP     16'h0100
`define AAO_GAIN_FULL     16'hFFFF

// Extra muted samples spent relocking after an asynchronous switch
`define AAO_RELOCK_SAMPLES 16'h0400

// Presence threshold: -48 dBFS is about 2^-8 of full scale
`define AAO_PRES_THRESH   24'h00_8000

// Output sample period at 48 kHz with a 125 MHz clock
`define AAO_CLK_HZ        125000000
`define AAO_OUT_HZ        48000
`define AAO_OUT_DIV       (`AAO_CLK_HZ / `AAO_OUT_HZ)

`endif

// [shared/aao_pkg.sv]
/*
  Types for the AES-to-analog output processor.
  Assumes aao_defines.svh supplies the numeric constants.
*/
package aao_pkg;

  // One AES subframe pair arriving from the crosspoint
  typedef struct packed {
    logic        valid;
    logic [23:0] left;
    logic [23:0] right;
    logic [1:0]  wlen;
    logic        sync_ok;
    logic [7:0]  cbits;
  } aao_aes_t;

  // Two processed channels handed to the rate converter and DAC
  typedef struct packed {
    logic        valid;
    logic [23:0] left;
    logic [23:0] right;
    logic [7:0]  cbits;
  } aao_pcm_t;

  // Fade sequencer: Gray codes along the path from AAO_IDLE to AAO_UP
  typedef enum logic [2:0] {
    AAO_IDLE   = 3'b000,
    AAO_DOWN   = 3'b001,
    AAO_SWITCH = 3'b011,
    AAO_RELOCK = 3'b010,
    AAO_UP     = 3'b110
  } aao_fade_t;

endpackage

// [tb/aao_core_properties.sv]
/*
  Port checker for the output processor, bound onto aao_core.
  Assumes one clock domain; the bench may pause clk_en between samples.
*/
`timescale 1ns/1ps
`default_nettype none
module aao_chk #(
  parameter int N_CH = 8
) (
  // Clock and reset
  input wire logic              mclk,
  input wire logic              rst_n,
  input wire logic              clk_en,
  // Audio
  input wire aao_pkg::aao_aes_t aes_in [N_CH],
  input wire aao_pkg::aao_pcm_t pcm_out [N_CH],
  input wire aao_pkg::aao_pcm_t mon_out [N_CH],
  // Converter control
  input wire logic [N_CH-1:0]   conv_grouped,
  input wire logic [N_CH-1:0]   conv_phase_src,
  input wire logic              dac_tick,
  // Read channel
  input wire logic              s_arvalid,
  input wire logic              s_arready,
  input wire logic              s_rvalid,
  input wire logic              s_rready,
  input wire logic [31:0]       s_rdata
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [11:0] tick_cnt_q;
  logic        tick_seen_q;
  // First gap after reset has unknown phase, so only later gaps are judged
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q  <= 12'h000;
      tick_seen_q <= 1'b0;
    end else if (clk_en) begin
      tick_cnt_q  <= dac_tick ? 12'h000 : tick_cnt_q + 12'h001;
      tick_seen_q <= tick_seen_q | dac_tick;
    end
  end
  a_pcm_after_strobe: assert property (
    pcm_out[0].valid |-> $past(aes_in[0].valid)) else $error("pcm early");
  a_mon_tap_copy: assert property (
    mon_out[0] == pcm_out[0]) else $error("monitor differs");
  a_cbits_marked: assert property (
    pcm_out[0].valid |-> pcm_out[0].cbits[1:0] == 2'b11)
    else $error("cbits not marked");
  a_tick_period: assert property (
    dac_tick && tick_seen_q |-> tick_cnt_q == 12'hA2B)
    else $error("tick period");
  a_tick_bound: assert property (
    tick_seen_q |-> tick_cnt_q <= 12'hA2B) else $error("tick missing");
  a_master_onehot: assert property (
    $onehot0(conv_phase_src)) else $error("two masters");
  a_master_grouped: assert property (
    (conv_phase_src & ~conv_grouped) == '0) else $error("master ungrouped");
  a_group_pairs: assert property (
    (conv_grouped & 8'h55) == ((conv_grouped >> 1) & 8'h55))
    else $error("pair split");
  a_read_answer: assert property (
    s_arvalid && s_arready |=> s_rvalid) else $error("read late");
  a_rdata_hold: assert property (
    s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data moved");
  c_tick: cover property (dac_tick);
  c_master: cover property (|conv_phase_src);
  c_sample: cover property (pcm_out[0].valid);
endmodule
bind aao_core aao_chk #(.N_CH(N_CH)) u_chk (
  .mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .aes_in(aes_in),
  .pcm_out(pcm_out), .mon_out(mon_out), .conv_grouped(conv_grouped),
  .conv_phase_src(conv_phase_src), .dac_tick(dac_tick),
  .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rvalid(s_rvalid),
  .s_rready(s_rready), .s_rdata(s_rdata));
`default_nettype wire

// [tb/aao_xpt_model.sv]
/*
  Crosspoint stand-in: eight AES streams with one shared strobe.
  Assumes the same clock as the core; amplitude set by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module aao_xpt_model #(
  parameter int N_CH   = 8,
  parameter int PERIOD = 16
) (
  // Clock and reset
  input  wire logic            mclk,
  input  wire logic            rst_n,
  // Stream settings
  input  wire logic [23:0]     amp,
  input  wire logic [1:0]      wlen,
  input  wire logic [N_CH-1:0] sync_ok,
  // Streams
  output aao_pkg::aao_aes_t    aes [N_CH]
);
  int cnt_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 0;
      for (int i = 0; i < N_CH; i++) aes[i] <= '0;
    end else begin
      cnt_q <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
      for (int i = 0; i < N_CH; i++) begin
        aes[i].valid   <= (cnt_q == PERIOD - 1);
        aes[i].left    <= amp;
        aes[i].right   <= amp >> 8;
        aes[i].wlen    <= wlen;
        aes[i].sync_ok <= sync_ok[i];
        aes[i].cbits   <= 8'h00;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/testbench.sv]
/*
  Self-checking bench for the output processor.
  Assumes the crosspoint model and the bound port checker.
*/
`include "aao_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int SP = 16;
  logic              mclk, rst_n, clk_en, awvalid, wvalid, bready;
  logic              arvalid, rready;
  logic [11:0]       awaddr, araddr;
  logic [31:0]       wdata;
  logic [7:0]        sync_ok;
  logic [1:0]        wlen;
  logic              awready, wready, bvalid, arready, rvalid, irq, tick;
  logic [1:0]        bresp, rresp;
  logic [31:0]       rdata;
  logic [7:0]        grp, phs;
  aao_pkg::aao_aes_t aes [8];
  aao_pkg::aao_pcm_t pcm [8];
  aao_pkg::aao_pcm_t mon [8];
  int                err_count, compares, cyc;
  // Low byte set so that dropping bits below the word length shows
  aao_xpt_model #(.PERIOD(SP)) u_xpt (.mclk(mclk), .rst_n(rst_n),
    .amp(24'h10_00FF), .wlen(wlen), .sync_ok(sync_ok), .aes(aes));
  aao_core u_dut (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
    .aes_in(aes), .pcm_out(pcm), .conv_grouped(grp), .conv_phase_src(phs),
    .dac_tick(tick), .mon_out(mon), .irq(irq), .s_awaddr(awaddr),
    .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata),
    .s_wstrb(4'hF), .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp),
    .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr),
    .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
    .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Free cycle count, so fade lengths do not depend on bus timing
  always @(posedge mclk) cyc <= cyc + 1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    @(posedge mclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done) begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      done = bvalid;
    end
    bready <= 1'b0;
    if (a > `AAO_OFS_PRESENCE) chk({30'h0, bresp}, 32'h0000_0002);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    logic done;
    done = 1'b0;
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done) begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
      d    = rdata;
      done = rvalid;
    end
    rready <= 1'b0;
    if (a > `AAO_OFS_PRESENCE) chk({30'h0, rresp}, 32'h0000_0002);
  endtask
  task automatic wait_pcm(output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 4 * SP && !ok; i++) begin
      @(posedge mclk);
      #1 ok = pcm[0].valid;
    end
  endtask
  task automatic t_regs();
    logic [31:0] d;
    rd(`AAO_OFS_CTRL, d);
    chk(d, `AAO_CTRL_RST);
    rd(`AAO_OFS_GROUP, d);
    chk(d, 32'h0000_0000);
    rd(12'h020, d);
    chk(d, 32'h0000_0000);
    wr(12'h020, 32'hFFFF_FFFF);
  endtask
  task automatic t_stream();
    logic        ok;
    logic [31:0] d;
    wait_pcm(ok);
    chk(ok, 1'b1);
    for (int i = 0; i < 8; i++) begin
      chk({pcm[i].valid, pcm[i].cbits[1:0]}, 3'b111);
      chk(pcm[i].right != 0 && pcm[i].left > pcm[i].right, 1'b1);
    end
    rd(`AAO_OFS_PRESENCE, d);
    chk(d, 32'h0000_5555);
    wr(`AAO_OFS_CTRL, 32'h0000_0000);
    wait_pcm(ok);
    chk(ok, 1'b0);
  endtask
  task automatic t_dither();
    logic        ok, diff;
    logic [23:0] a;
    wr(`AAO_OFS_CTRL, 32'h0000_0002);
    wait_pcm(ok);
    a = pcm[0].left;
    wait_pcm(ok);
    chk(pcm[0].left, a);
    wr(`AAO_OFS_CTRL, 32'h0000_0003);
    diff = 1'b0;
    repeat (16) begin
      wait_pcm(ok);
      diff |= (pcm[0].left != a);
    end
    chk(diff, 1'b1);
    wr(`AAO_OFS_CTRL, 32'h0000_0002);
  endtask
  task automatic t_wlen();
    logic        ok;
    logic [23:0] l24, l20;
    wait_pcm(ok);
    l24 = pcm[0].left;
    @(posedge mclk);
    wlen <= 2'h1;
    repeat (2) wait_pcm(ok);
    l20 = pcm[0].left;
    @(posedge mclk);
    wlen <= 2'h0;
    repeat (2) wait_pcm(ok);
    chk(ok && l20 < l24 && pcm[0].left < l20, 1'b1);
    @(posedge mclk);
    wlen <= 2'h2;
  endtask
  task automatic t_freeze();
    logic ok;
    wait_pcm(ok);
    @(posedge mclk);
    clk_en <= 1'b0;
    wait_pcm(ok);
    chk(ok, 1'b0);
    @(posedge mclk);
    clk_en <= 1'b1;
    wait_pcm(ok);
    chk(ok, 1'b1);
  endtask
  task automatic t_fade(input int ch, input logic [31:0] sel, output int n);
    logic [31:0] d;
    int          k;
    wr(`AAO_OFS_IRQ_MASK, 32'h0000_0000);
    wr(`AAO_OFS_SRCSEL, sel);
    n = cyc;
    k = 0;
    do begin
      rd(`AAO_OFS_STATUS, d);
      k++;
    end while (d[ch] && k < 20000);
    n = cyc - n;
    chk(d[ch], 1'b0);
    rd(`AAO_OFS_IRQ_STAT, d);
    chk(d[ch] && !irq, 1'b1);
    wr(`AAO_OFS_IRQ_MASK, 32'h1 << ch);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b1);
    wr(`AAO_OFS_IRQ_STAT, 32'h1 << ch);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b0);
  endtask
  task automatic t_fades();
    int ns, na;
    t_fade(0, 32'h0000_0001, ns);
    chk(ns > 500 * SP && ns < 530 * SP, 1'b1);
    sync_ok[1] <= 1'b0;
    t_fade(1, 32'h0000_0009, na);
    chk(na - ns > 1000 * SP && na - ns < 1050 * SP, 1'b1);
  endtask
  task automatic t_group();
    wr(`AAO_OFS_GROUP, 32'h0000_0002);
    wr(`AAO_OFS_MASTER, 32'h0000_0003);
    repeat (2) @(posedge mclk);
    chk({grp, phs}, 16'h0C08);
    wr(`AAO_OFS_MASTER, 32'h0000_0005);
    repeat (2) @(posedge mclk);
    chk({grp, phs}, 16'h0000);
  endtask
  task automatic summarize();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #600_000;
    err_count++;
    summarize();
  end
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    clk_en  = 1'b1;
    sync_ok = 8'hFF;
    wlen    = 2'h2;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_stream();
    t_dither();
    t_wlen();
    t_freeze();
    t_fades();
    t_group();
    summarize();
  end
endmodule
`default_nettype wire
